// File: hw/acp_pkg.sv
// Shared constants, types and decode helpers for the converter configuration and pin control
package acp_pkg;

  // APB geometry and channel count
  localparam int ACP_ADDR_W = 8;
  localparam int ACP_DATA_W = 32;
  localparam int ACP_REG_W = 8;
  localparam int ACP_NUM_CH = 24;
  localparam int ACP_CH_PER_REG = 8;

  // Register byte addresses, one aligned word each
  localparam logic [ACP_ADDR_W-1:0] ACP_ADDR_CFG = 8'h00;
  localparam logic [ACP_ADDR_W-1:0] ACP_ADDR_PIN_LOW = 8'h04;
  localparam logic [ACP_ADDR_W-1:0] ACP_ADDR_PIN_MID = 8'h08;
  localparam logic [ACP_ADDR_W-1:0] ACP_ADDR_PIN_HIGH = 8'h0c;

  // Configuration register field positions
  localparam int ACP_LOW_POWER_BIT = 7;
  localparam int ACP_DIV_MSB = 6;
  localparam int ACP_DIV_LSB = 5;
  localparam int ACP_LONG_SAMPLE_BIT = 4;
  localparam int ACP_RES_MSB = 3;
  localparam int ACP_RES_LSB = 2;
  localparam int ACP_SRC_MSB = 1;
  localparam int ACP_SRC_LSB = 0;

  // Reset values: every field cleared, so the undivided bus clock is chosen
  localparam logic [ACP_REG_W-1:0] ACP_CFG_RST = 8'h00;
  localparam logic [ACP_REG_W-1:0] ACP_PIN_RST = 8'h00;

  // Resolution encodings; the other two codes are reserved
  localparam logic [1:0] ACP_RES_8BIT = 2'h0;
  localparam logic [1:0] ACP_RES_10BIT = 2'h2;

  // Divider counter width, wide enough for the largest ratio minus one
  localparam int ACP_DIV_CNT_W = 3;

  // Clock source choices in field order
  typedef enum logic [1:0] {
    ACP_SRC_BUS,
    ACP_SRC_BUS_HALF,
    ACP_SRC_ALT,
    ACP_SRC_ASYNC
  } acp_src_t;

  // Register selected by an APB address
  typedef enum logic [2:0] {
    ACP_SEL_NONE,
    ACP_SEL_CFG,
    ACP_SEL_LOW,
    ACP_SEL_MID,
    ACP_SEL_HIGH
  } acp_sel_t;

  // Divide field to terminal count: ratios 1, 2, 4, 8
  function automatic logic [ACP_DIV_CNT_W-1:0] acp_div_last(input logic [1:0] div_sel);
    logic [ACP_DIV_CNT_W-1:0] last;
    last = 3'h0;
    unique case (div_sel)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      2'h3: last = 3'h7;
    endcase
    return last;
  endfunction

  // Address decode shared by read and write paths; absent registers decode as unmapped
  function automatic acp_sel_t acp_decode(input logic [ACP_ADDR_W-1:0] addr,
                                          input logic has_mid,
                                          input logic has_high);
    acp_sel_t sel;
    sel = ACP_SEL_NONE;
    if (addr == ACP_ADDR_CFG)
    begin
      sel = ACP_SEL_CFG;
    end
    else if (addr == ACP_ADDR_PIN_LOW)
    begin
      sel = ACP_SEL_LOW;
    end
    else if (addr == ACP_ADDR_PIN_MID && has_mid)
    begin
      sel = ACP_SEL_MID;
    end
    else if (addr == ACP_ADDR_PIN_HIGH && has_high)
    begin
      sel = ACP_SEL_HIGH;
    end
    return sel;
  endfunction

endpackage

// File: hw/acp_clk_div.sv
// Conversion clock source select and divider, producing a one-cycle tick per conversion clock
`timescale 1ns/10ps
`default_nettype none

module acp_clk_div (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] src_sel_i,
  input wire logic [1:0] div_sel_i,
  input wire logic restart_i,
  input wire logic alt_clk_i,
  input wire logic async_clk_i,
  output logic tick_o
);

  typedef struct packed {
    logic half;
    logic alt_prev;
    logic async_prev;
    logic [acp_pkg::ACP_DIV_CNT_W-1:0] cnt;
    logic tick;
  } acp_div_state_t;

  acp_div_state_t st_ff;
  acp_div_state_t nxt_st;
  logic src_tick;

  // One source tick per rising edge of the chosen source clock
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.half = ~st_ff.half;
    nxt_st.alt_prev = alt_clk_i;
    nxt_st.async_prev = async_clk_i;
    nxt_st.tick = 1'b0;
    src_tick = 1'b0;
    unique case (acp_pkg::acp_src_t'(src_sel_i))
      acp_pkg::ACP_SRC_BUS: src_tick = 1'b1;
      acp_pkg::ACP_SRC_BUS_HALF: src_tick = st_ff.half;
      acp_pkg::ACP_SRC_ALT: src_tick = alt_clk_i & ~st_ff.alt_prev;
      acp_pkg::ACP_SRC_ASYNC: src_tick = async_clk_i & ~st_ff.async_prev;
    endcase
    // Restart keeps a stale phase from the old setting out of the new clock
    if (restart_i)
    begin
      nxt_st.cnt = '0;
    end
    else if (src_tick)
    begin
      if (st_ff.cnt >= acp_pkg::acp_div_last(div_sel_i))
      begin
        nxt_st.cnt = '0;
        nxt_st.tick = 1'b1;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt + 3'h1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule // acp_clk_div

`default_nettype wire

// File: hw/acp_top.sv
// APB register block for converter configuration and analog pin disable control
//
// Notes on behaviour
// - Config bit 7 picks high speed when 0 and low power with a slower clock ceiling when 1.
// - Config bits 6:5 give divide ratios 1, 2, 4 and 8 for codes 00, 01, 10 and 11.
// - The conversion clock is the chosen source clock divided by the selected ratio.
// - Config bit 4 picks the short sample period when 0 and the long one when 1.
// - Config bits 3:2 pick 8-bit for 00 and 10-bit for 10, with 01 and 11 reserved.
// - Config bits 1:0 pick bus clock, bus clock halved, alternate clock or async clock.
// - Bit n of the low pin register governs the pin of channel n for channels 0 to 7.
// - Bits 0 to 7 of the middle pin register govern channels 8 to 15 in order.
// - Bits 0 to 7 of the high pin register govern channels 16 to 23 in order.
// - A pin bit of 1 cuts that pin's digital path and 0 leaves normal digital control.
// - Pin bits for channels with no external input are stored but drive nothing.
// - The middle and high pin registers can be left out of a build entirely.
// - Any write to the config register aborts a conversion in progress.
// - A disabled pin gets its output driver off, input reading zero and pullup off.
// - Changing the resolution field marks held conversion results invalid.
// - After reset the undivided bus clock is the conversion clock source.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module acp_top #(
  parameter logic [acp_pkg::ACP_NUM_CH-1:0] CH_PRESENT = 24'hffffff,
  parameter bit HAS_MID = 1'b1,
  parameter bit HAS_HIGH = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [acp_pkg::ACP_ADDR_W-1:0] paddr_i,
  input wire logic [acp_pkg::ACP_DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [acp_pkg::ACP_DATA_W-1:0] prdata_o,
  output logic pslverr_o,
  // Conversion clock sources
  input wire logic alt_clk_i,
  input wire logic async_clk_i,
  // Converter core controls
  output logic low_power_o,
  output logic long_sample_o,
  output logic [1:0] resolution_o,
  output logic [1:0] clock_source_o,
  output logic conversion_clock_tick_o,
  output logic conversion_abort_o,
  output logic result_invalid_o,
  // Pad path from the port logic and toward the pads
  input wire logic [acp_pkg::ACP_NUM_CH-1:0] port_out_en_i,
  input wire logic [acp_pkg::ACP_NUM_CH-1:0] port_pullup_en_i,
  input wire logic [acp_pkg::ACP_NUM_CH-1:0] pad_in_i,
  output logic [acp_pkg::ACP_NUM_CH-1:0] pad_out_en_o,
  output logic [acp_pkg::ACP_NUM_CH-1:0] pad_pullup_en_o,
  output logic [acp_pkg::ACP_NUM_CH-1:0] pad_in_buf_en_o,
  output logic [acp_pkg::ACP_NUM_CH-1:0] port_in_o
);

  localparam int NCH = acp_pkg::ACP_NUM_CH;
  localparam int RW = acp_pkg::ACP_REG_W;

  typedef struct packed {
    logic [RW-1:0] cfg;
    logic [RW-1:0] pin_low;
    logic [RW-1:0] pin_mid;
    logic [RW-1:0] pin_high;
    logic pready;
    logic [acp_pkg::ACP_DATA_W-1:0] prdata;
    logic pslverr;
    logic abort;
    logic invalid;
    logic [NCH-1:0] out_en;
    logic [NCH-1:0] pullup_en;
    logic [NCH-1:0] in_buf_en;
    logic [NCH-1:0] port_in;
  } acp_state_t;

  acp_state_t st_ff;
  acp_state_t nxt_st;

  acp_pkg::acp_sel_t sel;
  logic access;
  logic fire;
  logic wr_fire;
  logic cfg_wr;
  logic [RW-1:0] rd_byte;
  logic [NCH-1:0] pin_bits;
  logic [NCH-1:0] pin_off;

  // Reset value of the whole state
  localparam acp_state_t ST_RST = '{
    cfg: acp_pkg::ACP_CFG_RST,
    pin_low: acp_pkg::ACP_PIN_RST,
    pin_mid: acp_pkg::ACP_PIN_RST,
    pin_high: acp_pkg::ACP_PIN_RST,
    pready: 1'b0,
    prdata: 32'h0000_0000,
    pslverr: 1'b0,
    abort: 1'b0,
    invalid: 1'b0,
    out_en: 24'h000000,
    pullup_en: 24'h000000,
    in_buf_en: 24'h000000,
    port_in: 24'h000000
  };

  // Bus decode; one wait state, the write lands on the edge that sees pready
  assign sel = acp_pkg::acp_decode(paddr_i, HAS_MID, HAS_HIGH);
  assign access = psel_i & penable_i;
  assign fire = access & st_ff.pready;
  assign wr_fire = fire & pwrite_i & pstrb_i[0] & (sel != acp_pkg::ACP_SEL_NONE);
  assign cfg_wr = wr_fire & (sel == acp_pkg::ACP_SEL_CFG);

  // Channel-ordered view of the three pin registers
  assign pin_bits = {st_ff.pin_high, st_ff.pin_mid, st_ff.pin_low};

  // Per-channel disable: absent channels and omitted registers never act on a pad
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_pin
      localparam bit REG_PRESENT = (ch < acp_pkg::ACP_CH_PER_REG) ? 1'b1 :
                                   (ch < 2 * acp_pkg::ACP_CH_PER_REG) ? HAS_MID : HAS_HIGH;
      assign pin_off[ch] = pin_bits[ch] & CH_PRESENT[ch] & REG_PRESENT;
    end
  endgenerate

  // Read mux, zero-extended to the bus width
  always_comb
  begin
    rd_byte = '0;
    unique case (sel)
      acp_pkg::ACP_SEL_CFG: rd_byte = st_ff.cfg;
      acp_pkg::ACP_SEL_LOW: rd_byte = st_ff.pin_low;
      acp_pkg::ACP_SEL_MID: rd_byte = st_ff.pin_mid;
      acp_pkg::ACP_SEL_HIGH: rd_byte = st_ff.pin_high;
      acp_pkg::ACP_SEL_NONE: rd_byte = '0;
      default: rd_byte = '0;
    endcase
  end

  // Next state of registers, bus answer, pulses and pad gating
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.abort = 1'b0;
    nxt_st.invalid = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.pready = access & ~st_ff.pready;
    // Read data and error are set up in the cycle before pready rises
    if (access && !st_ff.pready)
    begin
      nxt_st.prdata = {{(acp_pkg::ACP_DATA_W - RW){1'b0}}, rd_byte};
      nxt_st.pslverr = (sel == acp_pkg::ACP_SEL_NONE);
    end
    else
    begin
      // Answer stands only in the pready cycle, so clear it on completion too
      nxt_st.prdata = '0;
    end
    // Register writes; absent registers decode as none and store nothing
    if (wr_fire)
    begin
      unique case (sel)
        acp_pkg::ACP_SEL_CFG:
        begin
          nxt_st.cfg = pwdata_i[RW-1:0];
          nxt_st.abort = 1'b1;
          if (pwdata_i[acp_pkg::ACP_RES_MSB:acp_pkg::ACP_RES_LSB] !=
              st_ff.cfg[acp_pkg::ACP_RES_MSB:acp_pkg::ACP_RES_LSB])
          begin
            nxt_st.invalid = 1'b1;
          end
        end
        acp_pkg::ACP_SEL_LOW: nxt_st.pin_low = pwdata_i[RW-1:0];
        acp_pkg::ACP_SEL_MID: nxt_st.pin_mid = pwdata_i[RW-1:0];
        acp_pkg::ACP_SEL_HIGH: nxt_st.pin_high = pwdata_i[RW-1:0];
        acp_pkg::ACP_SEL_NONE: nxt_st.cfg = st_ff.cfg;
        default: nxt_st.cfg = st_ff.cfg;
      endcase
    end
    // Pad path, registered so every pad output leaves a flip-flop
    nxt_st.out_en = port_out_en_i & ~pin_off;
    nxt_st.pullup_en = port_pullup_en_i & ~pin_off;
    nxt_st.in_buf_en = ~pin_off;
    nxt_st.port_in = pad_in_i & ~pin_off;
  end

  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= ST_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Divider restarts on a config write so the new ratio starts from a clean phase
  acp_clk_div u_clk_div (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .src_sel_i(st_ff.cfg[acp_pkg::ACP_SRC_MSB:acp_pkg::ACP_SRC_LSB]),
    .div_sel_i(st_ff.cfg[acp_pkg::ACP_DIV_MSB:acp_pkg::ACP_DIV_LSB]),
    .restart_i(st_ff.abort),
    .alt_clk_i(alt_clk_i),
    .async_clk_i(async_clk_i),
    .tick_o(conversion_clock_tick_o)
  );

  // Bus outputs
  assign pready_o = st_ff.pready;
  assign prdata_o = st_ff.prdata;
  assign pslverr_o = st_ff.pslverr;

  // Converter controls, straight from the configuration, abort and invalid flops
  assign low_power_o = st_ff.cfg[acp_pkg::ACP_LOW_POWER_BIT];
  assign long_sample_o = st_ff.cfg[acp_pkg::ACP_LONG_SAMPLE_BIT];
  assign resolution_o = st_ff.cfg[acp_pkg::ACP_RES_MSB:acp_pkg::ACP_RES_LSB];
  assign clock_source_o = st_ff.cfg[acp_pkg::ACP_SRC_MSB:acp_pkg::ACP_SRC_LSB];
  assign conversion_abort_o = st_ff.abort;
  assign result_invalid_o = st_ff.invalid;

  // Pad outputs
  assign pad_out_en_o = st_ff.out_en;
  assign pad_pullup_en_o = st_ff.pullup_en;
  assign pad_in_buf_en_o = st_ff.in_buf_en;
  assign port_in_o = st_ff.port_in;

  // Unused upper write lanes: registers are 8 bits in lane 0 only
  logic unused_lanes;
  assign unused_lanes = ^{pwdata_i[acp_pkg::ACP_DATA_W-1:RW], pstrb_i[3:1]};

endmodule // acp_top

`default_nettype wire

// File: verification/acp_pad_model.sv
// Pad and clock-source model standing at the far side of the control block
`timescale 1ns/10ps
`default_nettype none

module acp_pad_model (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  output logic [23:0] port_out_en_o,
  output logic [23:0] port_pullup_en_o,
  output logic [23:0] pad_in_o,
  output logic alt_clk_o,
  output logic async_clk_o
);
  logic [23:0] cnt_ff;

  // Free counter; pad levels move every cycle so a stale gate never passes unseen
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_ff <= 24'h000000;
    end
    else
    begin
      cnt_ff <= cnt_ff + 24'h000001;
    end
  end

  // Port logic requests and pad levels, all different patterns
  assign pad_in_o = cnt_ff ^ 24'ha5c3e1;
  assign port_out_en_o = ~cnt_ff;
  assign port_pullup_en_o = {cnt_ff[11:0], cnt_ff[23:12]};
  // Alternate clock period 8 cycles, async clock period 16 cycles
  assign alt_clk_o = cnt_ff[2];
  assign async_clk_o = cnt_ff[3];
endmodule // acp_pad_model
`default_nettype wire

// File: verification/acp_props_properties.sv
// Concurrent checks on the ports of the converter control block
`timescale 1ns/10ps
`default_nettype none

module acp_props #(
  parameter logic [23:0] CH_PRESENT = 24'hffffff
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic low_power_o,
  input wire logic long_sample_o,
  input wire logic [1:0] resolution_o,
  input wire logic [1:0] clock_source_o,
  input wire logic conversion_clock_tick_o,
  input wire logic conversion_abort_o,
  input wire logic result_invalid_o,
  input wire logic [23:0] port_out_en_i,
  input wire logic [23:0] pad_out_en_o,
  input wire logic [23:0] pad_pullup_en_o,
  input wire logic [23:0] pad_in_buf_en_o,
  input wire logic [23:0] port_in_o
);
  logic wr_cfg;
  logic [1:0] div_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Completed config write; the divide field is not visible at the ports, so track it
  assign wr_cfg = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h00 && pstrb_i[0];
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      div_ff <= 2'h0;
    end
    else if (wr_cfg)
    begin
      div_ff <= pwdata_i[6:5];
    end
  end

  // Tick spacing sequences; an abort restarts the divider, so it cancels attempts
  sequence s_gap8;
    (!conversion_clock_tick_o)[*7] ##1 conversion_clock_tick_o;
  endsequence
  sequence s_gap2;
    !conversion_clock_tick_o ##1 conversion_clock_tick_o;
  endsequence

  AST_ACCESS_WAIT: assert property ($rose(psel_i && penable_i) |=> pready_o)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  AST_UNMAPPED: assert property (psel_i && penable_i && pready_o
    && !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> pslverr_o)
    else $error("unmapped access without error");
  AST_CFG_FIELDS: assert property (wr_cfg |=> {low_power_o, long_sample_o, resolution_o,
    clock_source_o} == {$past(pwdata_i[7]), $past(pwdata_i[4:0])})
    else $error("config outputs differ from written fields");
  AST_ABORT: assert property (wr_cfg |=> conversion_abort_o)
    else $error("config write without abort");
  AST_NO_ABORT: assert property (!wr_cfg |=> !conversion_abort_o)
    else $error("abort without config write");
  AST_INVALID: assert property (wr_cfg && pwdata_i[3:2] != resolution_o |=> result_invalid_o)
    else $error("resolution change without invalid");
  AST_PIN_GATE: assert property (((pad_out_en_o | pad_pullup_en_o | port_in_o)
    & ~pad_in_buf_en_o) == 24'h000000)
    else $error("disabled pin still driven");
  AST_PAD_FOLLOW: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2)
    |-> pad_out_en_o == ($past(port_out_en_i) & pad_in_buf_en_o))
    else $error("pad output enable not following port");
  AST_TICK_DIV8: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || conversion_abort_o)
    conversion_clock_tick_o && clock_source_o == 2'h0 && div_ff == 2'h3 |=> s_gap8)
    else $error("divide by eight spacing wrong");
  AST_TICK_DIV2: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || conversion_abort_o)
    conversion_clock_tick_o && clock_source_o == 2'h0 && div_ff == 2'h1 |=> s_gap2)
    else $error("divide by two spacing wrong");
endmodule // acp_props

bind acp_top acp_props #(.CH_PRESENT(CH_PRESENT)) u_acp_props (.*);
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the converter configuration and pin control block
`timescale 1ns/10ps
`default_nettype none

module tb;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic [7:0] exp_rd;
    logic exp_err;
  } acp_row_t;
  // Channel 23 has no analog input in this build
  localparam logic [23:0] PRESENT = 24'h7fffff;
  localparam int EXP_TICKS [4] = '{64, 32, 8, 4};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, lp, ls, tick, abort_p, inval, alt, asy, err;
  logic [31:0] prdata, rd;
  logic [1:0] res, src;
  logic [23:0] oen, pue, pin, pad_oen, pad_pue, pad_ibe, port_in;
  int n_fail = 0;
  int checks_done = 0;
  int cnt;
  // Writes and reads with the outcome each should give
  acp_row_t rows [11] = '{
    '{1'b1, 8'h00, 32'h000000a5, 4'hf, 8'h00, 1'b0}, '{1'b0, 8'h00, 32'h0, 4'h0, 8'ha5, 1'b0},
    '{1'b1, 8'h04, 32'h0000003c, 4'h1, 8'h00, 1'b0}, '{1'b1, 8'h04, 32'h000000ff, 4'he, 8'h00, 1'b0},
    '{1'b0, 8'h04, 32'h0, 4'h0, 8'h3c, 1'b0}, '{1'b1, 8'h08, 32'hffffffff, 4'h1, 8'h00, 1'b0},
    '{1'b0, 8'h08, 32'h0, 4'h0, 8'hff, 1'b0}, '{1'b1, 8'h0c, 32'h00000081, 4'h1, 8'h00, 1'b0},
    '{1'b0, 8'h0c, 32'h0, 4'h0, 8'h81, 1'b0}, '{1'b1, 8'h10, 32'h00000055, 4'h1, 8'h00, 1'b1},
    '{1'b0, 8'h02, 32'h0, 4'h0, 8'h00, 1'b1}};

  always #4 clk = ~clk;

  acp_pad_model u_acp_pad_model (.core_clk_i(clk), .sys_rst_i(rst), .port_out_en_o(oen),
    .port_pullup_en_o(pue), .pad_in_o(pin), .alt_clk_o(alt), .async_clk_o(asy));

  acp_top #(.CH_PRESENT(PRESENT), .HAS_MID(1'b1), .HAS_HIGH(1'b1)) u_acp_top (
    .core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .alt_clk_i(alt), .async_clk_i(asy), .low_power_o(lp),
    .long_sample_o(ls), .resolution_o(res), .clock_source_o(src),
    .conversion_clock_tick_o(tick), .conversion_abort_o(abort_p), .result_invalid_o(inval),
    .port_out_en_i(oen), .port_pullup_en_i(pue), .pad_in_i(pin), .pad_out_en_o(pad_oen),
    .pad_pullup_en_o(pad_pue), .pad_in_buf_en_o(pad_ibe), .port_in_o(port_in));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; an idle cycle first keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("ready", 32'h1, {31'h0, pready});
  endtask

  // Counts conversion clock pulses over 64 cycles once the restart has settled
  task automatic count_ticks(output int c);
    c = 0;
    repeat (2) @(posedge clk);
    repeat (64)
    begin
      @(posedge clk);
      if (tick === 1'b1)
        c++;
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0, 4'h0, rd, err);
      chk("reset read", 32'h0, rd);
    end
    chk("reset source", 32'h0, {30'h0, src});
    $display("test reset done");
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].data, rows[i].strb, rd, err);
      if (!rows[i].wr)
        chk("read data", {24'h0, rows[i].exp_rd}, rd);
      chk("slave error", {31'h0, rows[i].exp_err}, {31'h0, err});
    end
    chk("buffer enable", {8'h0, ~(24'h81ff3c & PRESENT)}, {8'h0, pad_ibe});
    $display("test registers and pins done");
    // Every divide ratio and every resolution code, with mode bits varied alongside
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h00, {24'h0, i[0], i[1:0], i[1], i[1:0], 2'h0}, 4'h1, rd, err);
      count_ticks(cnt);
      chk("low power", {31'h0, i[0]}, {31'h0, lp});
      chk("long sample", {31'h0, i[1]}, {31'h0, ls});
      chk("resolution", {30'h0, i[1:0]}, {30'h0, res});
      chk("tick count", 32'(64 >> i), 32'(cnt));
    end
    // Other sources; the model's clocks are sampled, so allow one pulse of phase slack for the alternate and async clocks, none for bus half
    for (int j = 1; j < 4; j++)
    begin
      apb(1'b1, 8'h00, {30'h0, j[1:0]}, 4'h1, rd, err);
      count_ticks(cnt);
      chk("source", {30'h0, j[1:0]}, {30'h0, src});
      chk("source ticks", 32'h1, {31'h0, cnt >= EXP_TICKS[j] - j / 2 && cnt <= EXP_TICKS[j] + j / 2});
    end
    $display("test clocking done");
    // Mid-run reset must bring the low pin register, input buffer gates, low power and source back to their cleared state
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0, 4'h0, rd, err);
    chk("mid reset pins", 32'h0, rd);
    chk("mid reset buffer", 32'h00ffffff, {8'h0, pad_ibe});
    chk("mid reset power", 32'h0, {31'h0, lp});
    chk("mid reset source", 32'h0, {30'h0, src});
    $display("test mid-run reset done");
    end_sim;
  end

  // Whole run needs under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("mismatch watchdog expected finish seen timeout");
    end_sim;
  end
endmodule // tb
`default_nettype wire
